// File: src/sas_pkg.sv
// package for the successive approximation sequencer
package sas_pkg;
  // ==========================================
  // sizes and encodings
  localparam int SAS_BITS = 8;
  localparam logic [1:0] SAS_ST_IDLE = 2'h0;
  localparam logic [1:0] SAS_ST_TRIAL = 2'h1;
  localparam logic [1:0] SAS_ST_DONE = 2'h2;
  typedef enum logic [1:0]
  {
    SAS_IDLE = 2'b00,
    SAS_TRIAL = 2'b01,
    SAS_DONE = 2'b10
  } sas_state_t;
  // result and dac drive travel together
  typedef struct packed
  {
    logic [SAS_BITS-1:0] dac;
    logic [SAS_BITS-1:0] result;
  } sas_word_t;
  localparam logic [SAS_BITS-1:0] SAS_ZERO = 8'h00;
  localparam logic [SAS_BITS-1:0] SAS_MSB_ONE = 8'h80;
endpackage

// File: src/sas_bit_cell.sv
// one result latch of the sequencer
`timescale 1ns/10ps
module sas_bit_cell
  import sas_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // control
  input wire logic i_clear,
  input wire logic i_set,
  input wire logic i_decide,
  input wire logic i_comp_high,
  // state
  output logic o_bit
);
  logic next_bit;

  always_comb
  begin
    next_bit = o_bit;
    if (i_clear)
    begin
      next_bit = i_set;
    end
    else if (i_set)
    begin
      next_bit = 1'b1;
    end
    else if (i_decide && i_comp_high)
    begin
      // comparator high means the trial value overshoots the input
      next_bit = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_bit <= 1'b0;
    end
    else if (i_ce)
    begin
      o_bit <= next_bit;
    end
  end
endmodule

// File: src/sas_sequencer.sv
// successive approximation sequencer top
// Operation
// - an n-bit conversion takes n plus one clock cycles
// - first trial drives only the most significant dac bit
// - keep tried bit if input reaches or exceeds trial value, else clear it
// - start loads one into first trial stage, sets first latch, enables top bit
// - low comparator keeps latch at one, otherwise latch cleared before next trial
// - each clock with i_ce high advances the trial one by one stage until all tried
// - after last trial the done output goes high and stays high until the next start to flag a valid result
// - eight bits give eight trial periods plus one, nine clocks in all
// - decision comes from comparator polarity of input minus dac current drop
// - at start clear all latches but msb, which is set, load trial register with one in its top stage
// - conversion begins when start is sampled high on a rising edge while no conversion is running
`timescale 1ns/10ps
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int N_BITS = SAS_BITS
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // control
  input wire logic i_start,
  input wire logic i_comp_high,
  // converter side
  output logic [N_BITS-1:0] o_dac_bits,
  output logic [N_BITS-1:0] o_result,
  output logic o_done,
  output logic o_busy
);
  // ==========================================
  // trial shift register and sequencing
  sas_state_t state;
  sas_state_t next_state;
  logic [N_BITS-1:0] trial;
  logic [N_BITS-1:0] next_trial;
  logic next_done;
  logic [N_BITS-1:0] latch_q;
  logic start_now;
  logic [N_BITS-1:0] trial_onehot_start;

  assign trial_onehot_start = {1'b1, {(N_BITS-1){1'b0}}};
  assign start_now = i_start && (state != SAS_TRIAL);

  always_comb
  begin
    next_state = state;
    next_trial = trial;
    next_done = o_done;
    case (state)
      SAS_IDLE, SAS_DONE:
      begin
        if (start_now)
        begin
          next_state = SAS_TRIAL;
          next_trial = trial_onehot_start;
          next_done = 1'b0;
        end
      end
      SAS_TRIAL:
      begin
        next_trial = trial >> 1;
        if (trial[0])
        begin
          // last trial, no extra cycle: the last decision is taken and done raised on this edge
          next_state = SAS_DONE;
          next_done = 1'b1;
        end
      end
      default:
      begin
        next_state = SAS_IDLE;
        next_trial = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= SAS_IDLE;
      trial <= '0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      trial <= next_trial;
      o_done <= next_done;
      o_busy <= (next_state == SAS_TRIAL);
    end
  end

  // ==========================================
  // result latches, one per bit
  // latch k is set when its trial begins and judged when the trial leaves it
  genvar g;
  generate
    for (g = 0; g < N_BITS; g++)
    begin : g_cell
      logic set_here;
      if (g == N_BITS-1)
      begin : g_top
        assign set_here = start_now;
      end
      else
      begin : g_low
        assign set_here = (state == SAS_TRIAL) && trial[g+1];
      end
      sas_bit_cell u_cell (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_clear(start_now),
        .i_set(set_here),
        .i_decide((state == SAS_TRIAL) && trial[g]),
        .i_comp_high(i_comp_high),
        .o_bit(latch_q[g])
      );
    end
  endgenerate

  // the dac is driven by the latch flops themselves: a registered copy would lag
  // one cycle and the comparator would then judge the previous trial value
  assign o_dac_bits = latch_q;

  // registered result
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_result <= '0;
    end
    else if (i_ce)
    begin
      // result only refreshes on completion so it holds while done is high
      if (next_state == SAS_DONE && state == SAS_TRIAL)
      begin
        o_result <= {latch_q[N_BITS-1:1], latch_q[0] & ~i_comp_high};
      end
    end
  end

  // ==========================================
  // checks
  property p_start_msb;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_ce && start_now) |=> o_dac_bits == trial_onehot_start;
  endproperty
  a_start_msb: assert property (p_start_msb) else $error("msb not alone after start");

  property p_nine_cycles;
    @(posedge i_ref_clk) disable iff (i_reset)
      (start_now && i_ce) ##1 (i_ce [*8]) |=> o_done;
  endproperty
  a_nine_cycles: assert property (p_nine_cycles) else $error("done not on time");

  property p_shift;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && !trial[0]) |=> $onehot(trial);
  endproperty
  a_shift: assert property (p_shift) else $error("trial not one-hot");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
      (o_done && !start_now) |=> $stable(o_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved while done");

  property p_done_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
      (start_now && i_ce) |=> !o_done && o_busy;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared");

  property p_clear_low;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && trial[N_BITS-1] && i_comp_high) |=> !latch_q[N_BITS-1];
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("msb kept on high comp");

  property p_keep;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && trial[N_BITS-1] && !i_comp_high) |=> latch_q[N_BITS-1];
  endproperty
  a_keep: assert property (p_keep) else $error("msb lost on low comp");

  property p_begin;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_start && state != SAS_TRIAL && i_ce) |=> state == SAS_TRIAL;
  endproperty
  a_begin: assert property (p_begin) else $error("start ignored");

  property p_refuse;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && i_start && !trial[0]) |=> trial == ($past(trial) >> 1);
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken while busy");

  property p_decide;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && !trial[0])
        |=> (|(latch_q & $past(trial))) == !$past(i_comp_high);
  endproperty
  a_decide: assert property (p_decide) else $error("tried bit judged wrongly");

  property p_last;
    @(posedge i_ref_clk) disable iff (i_reset)
      (state == SAS_TRIAL && i_ce && trial[0])
        |=> o_done && o_result[0] == !$past(i_comp_high);
  endproperty
  a_last: assert property (p_last) else $error("last bit or done wrong");

  property p_exclusive;
    @(posedge i_ref_clk) disable iff (i_reset)
      !(o_busy && o_done);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("busy and done together");

  c_conv: cover property (@(posedge i_ref_clk) disable iff (i_reset) start_now ##9 o_done);
  c_all_one: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    o_done && (&o_result));
  c_back: cover property (@(posedge i_ref_clk) disable iff (i_reset) o_done && i_start);
  c_refused: cover property (@(posedge i_ref_clk) disable iff (i_reset) o_busy && i_start);
endmodule

// File: tb/sas_comp_model.sv
// comparator and current dac model facing the sequencer
`timescale 1ns/10ps
module sas_comp_model
  import sas_pkg::*;
(
  // dac drive and analog input code
  input wire logic [SAS_BITS-1:0] i_dac_bits,
  input wire logic [SAS_BITS-1:0] i_vin,
  // comparator
  output logic o_comp_high
);
  // ==========================================
  // comparison
  // settles at once: the slowest legal far side is not modelled
  assign o_comp_high = (i_dac_bits > i_vin);
endmodule

// File: tb/successive_approx_sequencer_tb_top.sv
// testbench for the successive approximation sequencer
`timescale 1ns/10ps
module successive_approx_sequencer_tb_top
  import sas_pkg::*;
;
  // ==========================================
  // signals
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  logic i_start = 1'b0;
  logic comp;
  logic [SAS_BITS-1:0] vin = 8'h00;
  logic [SAS_BITS-1:0] dac;
  logic [SAS_BITS-1:0] result;
  logic done;
  logic busy;
  int failures = 0;
  int n_compared = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  sas_sequencer dut_u (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(i_ce), .i_start(i_start),
    .i_comp_high(comp), .o_dac_bits(dac), .o_result(result), .o_done(done), .o_busy(busy));
  sas_comp_model model_u (.i_dac_bits(dac), .i_vin(vin), .o_comp_high(comp));
  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one conversion; stall freezes the clock enable, poke retries start mid-run
  task automatic conv(input logic [7:0] v, input int stall, input bit poke);
    int n;
    @(negedge i_ref_clk);
    vin = v;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    // n counts cycles from the one in which start was raised
    n = 1;
    check({7'h00, busy}, 8'h01);
    check({7'h00, done}, 8'h00);
    check(dac, 8'h80);
    while (done !== 1'b1 && n < 40)
    begin
      i_ce = !(n >= 3 && n < 3 + stall);
      i_start = poke && n == 4;
      @(negedge i_ref_clk);
      n++;
    end
    check(8'(n), 8'(9 + stall));
    check(result, v);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    repeat (16) @(negedge i_ref_clk);
    check({result, dac}, 16'h0000);
    check({6'h00, done, busy}, 8'h00);
    i_reset = 1'b0;
  endtask
  task automatic t_codes();
    logic [7:0] codes [8] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h55, 8'hAA, 8'h01, 8'hFE};
    foreach (codes[i])
      conv(codes[i], 0, 1'b0);
  endtask
  task automatic t_stall_refuse();
    conv(8'hA3, 4, 1'b0);
    conv(8'h3C, 0, 1'b1);
  endtask
  task automatic t_hold();
    conv(8'h96, 0, 1'b0);
    vin = 8'h11;
    repeat (6) @(negedge i_ref_clk);
    check(result, 8'h96);
    check({7'h00, done}, 8'h01);
  endtask
  // done fed straight back into start: conversions follow each other every n plus one cycles
  task automatic t_loop();
    int gap;
    int rises;
    logic seen;
    vin = 8'h6D;
    // the first start is only raised at the first falling edge of the loop
    gap = -1;
    rises = 0;
    seen = done;
    while (rises < 3 && gap < 40)
    begin
      @(negedge i_ref_clk);
      gap++;
      if (done === 1'b1 && seen !== 1'b1)
      begin
        rises++;
        check(8'(gap), 8'h09);
        check(result, vin);
        gap = 0;
      end
      seen = done;
      i_start = done && (rises < 3);
    end
    check(8'(rises), 8'h03);
  endtask
  task automatic t_mid_reset();
    @(negedge i_ref_clk);
    i_start = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    i_start = 1'b0;
    i_reset = 1'b1;
    @(negedge i_ref_clk);
    check({6'h00, done, busy}, 8'h00);
    check({result, dac}, 16'h0000);
    i_reset = 1'b0;
    conv(8'h5A, 0, 1'b0);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    t_reset();
    t_codes();
    t_loop();
    t_stall_refuse();
    t_hold();
    t_mid_reset();
    end_of_test();
  end
  initial
  begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule
